// *** wdrs_consts.svh ***
// Constants of the watchdog and reset-cause block
`ifndef WDRS_CONSTS_SVH
`define WDRS_CONSTS_SVH
// Register byte offsets, low address byte
`define WDRS_OFS_CAUSE     8'h00
`define WDRS_OFS_CTRL      8'h04
`define WDRS_OFS_EVT       8'h08
`define WDRS_OFS_MASK      8'h0C
// Reset-cause flag positions
`define WDRS_CAUSE_POWER   0
`define WDRS_CAUSE_PIN     1
`define WDRS_CAUSE_LOW     2
`define WDRS_CAUSE_TIMEOUT 3
`define WDRS_CAUSE_DEBUG   4
`define WDRS_CAUSE_MSB     4
// Control field positions
`define WDRS_CTRL_WIN      4
`define WDRS_CTRL_EN       3
`define WDRS_CTRL_SEL_MSB  2
// Event status and mask positions
`define WDRS_EVT_TIMEOUT   0
`define WDRS_EVT_LOW       1
`define WDRS_EVT_PIN       2
`define WDRS_EVT_DEBUG     3
`define WDRS_EVT_MSB       3
// Reset values
`define WDRS_CAUSE_RST     5'h01
`define WDRS_SEL_RST       3'h0
`define WDRS_EVT_RST       4'h0
`define WDRS_MASK_RST      4'h0
// Timing counts
`define WDRS_WINDOW_CYCLES 3'h4
`define WDRS_BASE_TICKS    16384
`define WDRS_CNT_W         22
// Synchronised input positions
`define WDRS_IN_PIN        0
`define WDRS_IN_LOW        1
`define WDRS_IN_DEBUG      2
`define WDRS_IN_FUSE       3
`define WDRS_IN_OSC        4
`define WDRS_IN_W          5
`endif

// *** wdrs_pkg.sv ***
// Types of the watchdog and reset-cause block
package wdrs_pkg;
    typedef logic [2:0] wdrs_sel_t;

    typedef struct packed {
        logic [4:0] cause;
        logic       win;
        logic [2:0] win_cnt;
        logic       en;
        wdrs_sel_t  sel;
        logic [3:0] evt;
        logic [3:0] mask;
        logic       osc_prev;
        logic [2:0] src_prev;
        logic       dph_wr;
        logic [7:0] dph_addr;
        logic [31:0] rdata;
    } wdrs_state_t;
endpackage

// *** wdrs_wdt_if.sv ***
// Control and expiry signals between register logic and the time-out counter
`timescale 1ns/1ns
interface wdrs_wdt_if;
    import wdrs_pkg::*;
    logic      run;
    wdrs_sel_t sel;
    logic      tick;
    logic      clear;
    logic      expire;
    modport ctl  (output run, output sel, output tick, output clear, input expire);
    modport core (input run, input sel, input tick, input clear, output expire);
endinterface

// *** wdrs_sync.sv ***
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
module wdrs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } wdrs_sync_state_t;

    wdrs_sync_state_t q_r;
    wdrs_sync_state_t q_nxt;

    always_comb begin
        q_nxt      = q_r;
        q_nxt.meta = async_in;
        q_nxt.sync = q_r.meta;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign sync_out = q_r.sync;
endmodule

// *** wdrs_wdt_core.sv ***
// Watchdog time-out counter fed by oscillator ticks
`timescale 1ns/1ns
`include "wdrs_consts.svh"
module wdrs_wdt_core import wdrs_pkg::*; #(
    parameter int BASE_TICKS = `WDRS_BASE_TICKS,
    parameter int CNT_W      = `WDRS_CNT_W
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // Control from register logic
    wdrs_wdt_if.core  wdt
);

    localparam logic [CNT_W-1:0] BASE_V = CNT_W'(BASE_TICKS);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             expire;
    } wdrs_core_state_t;

    wdrs_core_state_t q_r;
    wdrs_core_state_t q_nxt;
    logic [CNT_W-1:0] limit;

    always_comb begin
        limit        = (BASE_V << wdt.sel) - 1'b1; // RULE_13
        q_nxt        = q_r;
        q_nxt.expire = 1'b0;
        if (!wdt.run || wdt.clear) begin
            q_nxt.cnt = '0; // RULE_15
        end else if (wdt.tick) begin
            if (q_r.cnt >= limit) begin
                q_nxt.cnt    = '0;
                q_nxt.expire = 1'b1; // RULE_14
            end else begin
                q_nxt.cnt = q_r.cnt + 1'b1; // RULE_17
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign wdt.expire = q_r.expire;
endmodule

// *** wdrs_top.sv ***
// Watchdog control and reset-cause status with AHB-Lite register access
//
// How it works
// RULE_01: debug-port reset sets flag bit four
// RULE_02: watchdog reset sets flag bit three
// RULE_03: brown-out reset sets flag bit two
// RULE_04: pin reset sets flag bit one
// RULE_05: power-up sets bit zero; zero-write clears
// RULE_06: software reads then clears flags early
// RULE_07: control bits seven to five read zero
// RULE_08: change-window bit self-clears four cycles later
// RULE_09: enable sets freely; clears only in window
// RULE_10: software disables with two timed writes
// RULE_11: always-on level ignores every disable attempt
// RULE_12: time-out select changes only inside window
// RULE_13: select code doubles count from 16K ticks
// RULE_14: expiry gives one-cycle reset pulse
// RULE_15: restart, disable, chip reset clear counter
// RULE_16: always-on level forces enable, reads one
// RULE_17: window in core clock, ticks synchronised
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`include "wdrs_consts.svh"
module wdrs_top import wdrs_pkg::*; #(
    parameter int BASE_TICKS = `WDRS_BASE_TICKS,
    parameter int CNT_W      = `WDRS_CNT_W
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Reset sources and fuse, asynchronous
    input  wire logic        pin_reset_in,
    input  wire logic        low_supply_in,
    input  wire logic        debug_reset_in,
    input  wire logic        always_on_fuse,
    // Watchdog oscillator, asynchronous
    input  wire logic        wdt_osc_in,
    // Restart instruction strobe, core clock
    input  wire logic        restart_req,
    // Outputs
    output logic             wdt_reset_pulse,
    output logic             irq
);

    wdrs_state_t           q_r;
    wdrs_state_t           q_nxt;
    logic [`WDRS_IN_W-1:0] raw_in;
    logic [`WDRS_IN_W-1:0] sync_in;
    logic                  pin_s;
    logic                  low_s;
    logic                  dbg_s;
    logic                  lvl2;
    logic                  osc_s;
    logic                  chip_rst;
    logic                  bus_take;
    logic                  wr_cause;
    logic                  wr_ctrl;
    logic                  wr_evt;
    logic                  wr_mask;
    logic [7:0]            wd;
    logic [31:0]           rd_word;
    logic [3:0]            evt_set;

    wdrs_wdt_if wdt ();

    // Input synchronisers
    assign raw_in[`WDRS_IN_PIN]   = pin_reset_in;
    assign raw_in[`WDRS_IN_LOW]   = low_supply_in;
    assign raw_in[`WDRS_IN_DEBUG] = debug_reset_in;
    assign raw_in[`WDRS_IN_FUSE]  = always_on_fuse;
    assign raw_in[`WDRS_IN_OSC]   = wdt_osc_in;

    wdrs_sync #(
        .WIDTH    (`WDRS_IN_W)
    ) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in (raw_in),
        .sync_out (sync_in)
    );

    assign pin_s = sync_in[`WDRS_IN_PIN];
    assign low_s = sync_in[`WDRS_IN_LOW];
    assign dbg_s = sync_in[`WDRS_IN_DEBUG];
    assign lvl2  = sync_in[`WDRS_IN_FUSE];
    assign osc_s = sync_in[`WDRS_IN_OSC];

    // Time-out counter
    wdrs_wdt_core #(
        .BASE_TICKS (BASE_TICKS),
        .CNT_W      (CNT_W)
    ) u_core (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .wdt        (wdt)
    );

    // Any chip reset source, including own expiry
    assign chip_rst = pin_s | low_s | dbg_s | wdt.expire;

    assign wdt.run   = q_r.en | lvl2; // RULE_16
    assign wdt.sel   = q_r.sel;
    assign wdt.tick  = osc_s & ~q_r.osc_prev; // RULE_17
    assign wdt.clear = restart_req | chip_rst; // RULE_15

    // Bus decode
    assign bus_take = hsel & hready & htrans[1];
    assign wd       = hwdata[7:0];

    always_comb begin
        wr_cause = 1'b0;
        wr_ctrl  = 1'b0;
        wr_evt   = 1'b0;
        wr_mask  = 1'b0;
        if (!q_r.dph_wr) begin
            wr_cause = 1'b0;
        end else if (q_r.dph_addr == `WDRS_OFS_CAUSE) begin
            wr_cause = 1'b1;
        end else if (q_r.dph_addr == `WDRS_OFS_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (q_r.dph_addr == `WDRS_OFS_EVT) begin
            wr_evt = 1'b1;
        end else if (q_r.dph_addr == `WDRS_OFS_MASK) begin
            wr_mask = 1'b1;
        end
    end

    // Read multiplexer
    always_comb begin
        rd_word = 32'h0000_0000;
        if (haddr[7:0] == `WDRS_OFS_CAUSE) begin
            rd_word[`WDRS_CAUSE_MSB:0] = q_r.cause;
        end else if (haddr[7:0] == `WDRS_OFS_CTRL) begin
            rd_word[`WDRS_CTRL_WIN]         = q_r.win;
            rd_word[`WDRS_CTRL_EN]          = q_r.en | lvl2; // RULE_16
            rd_word[`WDRS_CTRL_SEL_MSB:0]   = q_r.sel; // RULE_07
        end else if (haddr[7:0] == `WDRS_OFS_EVT) begin
            rd_word[`WDRS_EVT_MSB:0] = q_r.evt;
        end else if (haddr[7:0] == `WDRS_OFS_MASK) begin
            rd_word[`WDRS_EVT_MSB:0] = q_r.mask;
        end
    end

    // Interrupt events
    always_comb begin
        evt_set                    = 4'h0;
        evt_set[`WDRS_EVT_TIMEOUT] = wdt.expire;
        evt_set[`WDRS_EVT_LOW]     = low_s & ~q_r.src_prev[`WDRS_IN_LOW];
        evt_set[`WDRS_EVT_PIN]     = pin_s & ~q_r.src_prev[`WDRS_IN_PIN];
        evt_set[`WDRS_EVT_DEBUG]   = dbg_s & ~q_r.src_prev[`WDRS_IN_DEBUG];
    end

    always_comb begin
        q_nxt          = q_r;
        q_nxt.osc_prev = osc_s;
        q_nxt.src_prev = {dbg_s, low_s, pin_s};

        // Address phase capture
        q_nxt.dph_wr = bus_take & hwrite;
        if (bus_take) begin
            q_nxt.dph_addr = haddr[7:0];
        end
        if (bus_take && !hwrite) begin
            q_nxt.rdata = rd_word;
        end

        // Reset-cause flags: zero-write clears, a set in the same cycle wins
        if (wr_cause) begin
            q_nxt.cause = q_r.cause & wd[`WDRS_CAUSE_MSB:0]; // RULE_05
        end
        if (dbg_s) begin
            q_nxt.cause[`WDRS_CAUSE_DEBUG] = 1'b1; // RULE_01
        end
        if (wdt.expire) begin
            q_nxt.cause[`WDRS_CAUSE_TIMEOUT] = 1'b1; // RULE_02
        end
        if (low_s) begin
            q_nxt.cause[`WDRS_CAUSE_LOW] = 1'b1; // RULE_03
        end
        if (pin_s) begin
            q_nxt.cause[`WDRS_CAUSE_PIN] = 1'b1; // RULE_04
        end

        // Change window countdown
        if (q_r.win) begin
            if (q_r.win_cnt == 3'h0) begin
                q_nxt.win = 1'b0; // RULE_08
            end else begin
                q_nxt.win_cnt = q_r.win_cnt - 1'b1; // RULE_17
            end
        end

        // Control register write
        if (wr_ctrl) begin
            if (wd[`WDRS_CTRL_EN]) begin
                q_nxt.en = 1'b1; // RULE_09
            end else if (q_r.win && !lvl2) begin
                q_nxt.en = 1'b0; // RULE_11
            end
            if (q_r.win) begin
                q_nxt.sel = wd[`WDRS_CTRL_SEL_MSB:0]; // RULE_12
            end
            if (wd[`WDRS_CTRL_WIN]) begin
                q_nxt.win     = 1'b1;
                q_nxt.win_cnt = `WDRS_WINDOW_CYCLES - 3'h1; // RULE_08
            end else begin
                q_nxt.win = 1'b0;
            end
        end

        // Chip reset restores the control register
        if (chip_rst) begin
            q_nxt.en      = 1'b0;
            q_nxt.sel     = `WDRS_SEL_RST;
            q_nxt.win     = 1'b0;
            q_nxt.win_cnt = 3'h0;
        end

        // Event status: write one clears, a set in the same cycle wins
        if (wr_evt) begin
            q_nxt.evt = q_r.evt & ~wd[`WDRS_EVT_MSB:0];
        end
        q_nxt.evt = q_nxt.evt | evt_set;

        if (wr_mask) begin
            q_nxt.mask = wd[`WDRS_EVT_MSB:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q_r          <= '0;
            q_r.cause    <= `WDRS_CAUSE_RST;
            q_r.sel      <= `WDRS_SEL_RST;
            q_r.evt      <= `WDRS_EVT_RST;
            q_r.mask     <= `WDRS_MASK_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign hrdata          = q_r.rdata;
    assign wdt_reset_pulse = wdt.expire; // RULE_14
    assign irq             = |(q_r.evt & q_r.mask);
endmodule

// *** wdrs_top_props.sv ***
// Port checker of the watchdog and reset-cause block
`timescale 1ns/1ns
module wdrs_top_props (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        nrst,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    // Sources and outputs
    input wire logic        pin_reset_in,
    input wire logic        low_supply_in,
    input wire logic        debug_reset_in,
    input wire logic        always_on_fuse,
    input wire logic        wdt_osc_in,
    input wire logic        wdt_reset_pulse,
    input wire logic        irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic rd_req;
    assign rd_req = hsel && hready && htrans[1] && !hwrite;
    rsv_zero_a: assert property (rd_req && haddr[7:0] == 8'h04 |=> hrdata[31:5] == 27'h0)
        else $error("control read shows reserved bits");
    unmapped_zero_a: assert property (rd_req && haddr[7:0] > 8'h0C |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    pulse_one_a: assert property ($rose(wdt_reset_pulse) |=> !wdt_reset_pulse)
        else $error("reset pulse longer than one cycle");
    pulse_osc_a: assert property ($rose(wdt_reset_pulse) |-> $past(wdt_osc_in, 2) || $past(wdt_osc_in, 3))
        else $error("reset pulse without oscillator edge");
    pin_flag_a: assert property (pin_reset_in [*4] ##0 rd_req && haddr[7:0] == 8'h00 |=> hrdata[1])
        else $error("pin flag not set");
    low_flag_a: assert property (low_supply_in [*4] ##0 rd_req && haddr[7:0] == 8'h00 |=> hrdata[2])
        else $error("low supply flag not set");
    dbg_flag_a: assert property (debug_reset_in [*4] ##0 rd_req && haddr[7:0] == 8'h00 |=> hrdata[4])
        else $error("debug flag not set");
    fuse_en_a: assert property (always_on_fuse [*4] ##0 rd_req && haddr[7:0] == 8'h04 |=> hrdata[3])
        else $error("enable not one under fuse");
    rst_quiet_a: assert property ($rose(nrst) |-> !irq && !wdt_reset_pulse)
        else $error("outputs active after reset");
endmodule
bind wdrs_top wdrs_top_props chk (.core_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hrdata, .pin_reset_in, .low_supply_in, .debug_reset_in, .always_on_fuse, .wdt_osc_in,
    .wdt_reset_pulse, .irq);

// *** tb_wdrs_top.sv ***
// Self-checking bench of the watchdog and reset-cause block
`timescale 1ns/1ns
`include "wdrs_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_wdrs_top import wdrs_pkg::*;;
    localparam int BASE = 4;
    logic        core_clk = 0, nrst = 0, hsel = 1, hwrite = 0, rd_dp = 0;
    logic        restart_req = 0, wdt_osc_in = 0, always_on_fuse = 0;
    logic [2:0]  src = 0;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, ticks = 0, note, hrdata;
    logic        hreadyout, hresp, wdt_reset_pulse, irq;
    logic [31:0] rq[$], pq[$];
    int          mismatches = 0, tests_run = 0;
    int          cbit[3] = '{`WDRS_CAUSE_PIN, `WDRS_CAUSE_LOW, `WDRS_CAUSE_DEBUG};
    int          ebit[3] = '{`WDRS_EVT_PIN, `WDRS_EVT_LOW, `WDRS_EVT_DEBUG};
    wdrs_top #(.BASE_TICKS(BASE)) uut (.core_clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .pin_reset_in(src[0]), .low_supply_in(src[1]), .debug_reset_in(src[2]),
        .always_on_fuse, .wdt_osc_in, .restart_req, .wdt_reset_pulse, .irq);
    initial forever #10 core_clk = ~core_clk;
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr  <= {24'($urandom), a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            wdt_osc_in <= 1'b1;
            ticks      <= ticks + 1;
            repeat (4) @(posedge core_clk);
            wdt_osc_in <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask
    task automatic irq_is(input logic e);
        @(posedge core_clk);
        #1 `CHK(irq, e)
    endtask
    // Monitor: oldest note against each read result and each reset pulse
    always @(posedge core_clk) begin
        if (rd_dp) begin
            note = rq.pop_front();
            `CHK(hrdata, note)
        end
        if (wdt_reset_pulse === 1'b1) begin
            note = pq.pop_front();
            `CHK(ticks, note)
        end
        rd_dp <= htrans[1] && !hwrite && hreadyout;
    end
    initial begin
        void'($urandom(94));
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        rd(`WDRS_OFS_CAUSE, 32'h01);
        wr(8'h10, $urandom);
        rd(8'h10, 32'h0);
        rd(`WDRS_OFS_CTRL, 32'h0);
        rd(`WDRS_OFS_EVT, 32'h0);
        rd(`WDRS_OFS_MASK, 32'h0);
        wr(`WDRS_OFS_CTRL, 32'hE8);
        rd(`WDRS_OFS_CTRL, 32'h08);
        wr(`WDRS_OFS_CTRL, 32'h05);
        rd(`WDRS_OFS_CTRL, 32'h08);
        wr(`WDRS_OFS_CTRL, 32'h10);
        wr(`WDRS_OFS_CTRL, 32'h0D);
        rd(`WDRS_OFS_CTRL, 32'h0D);
        wr(`WDRS_OFS_CTRL, 32'h10);
        rd(`WDRS_OFS_CTRL, 32'h1D);
        repeat (6) @(posedge core_clk);
        rd(`WDRS_OFS_CTRL, 32'h0D);
        wr(`WDRS_OFS_CTRL, 32'h0B);
        rd(`WDRS_OFS_CTRL, 32'h0D);
        wr(`WDRS_OFS_CTRL, 32'h18);
        wr(`WDRS_OFS_CTRL, 32'h00);
        rd(`WDRS_OFS_CTRL, 32'h00);
        wr(`WDRS_OFS_CAUSE, 32'h0);
        for (int s = 0; s < 8; s++) begin
            wr(`WDRS_OFS_CTRL, 32'h10);
            wr(`WDRS_OFS_CTRL, 32'h08 | s);
            tick(3);
            restart_req <= 1'b1;
            ticks       <= 0;
            @(posedge core_clk);
            restart_req <= 1'b0;
            pq.push_back(BASE << s);
            tick(BASE << s);
            rd(`WDRS_OFS_CTRL, 32'h0);
            rd(`WDRS_OFS_CAUSE, 32'h08);
            wr(`WDRS_OFS_CAUSE, 32'h0);
            rd(`WDRS_OFS_CAUSE, 32'h0);
        end
        wr(`WDRS_OFS_EVT, 32'hF);
        wr(`WDRS_OFS_MASK, 32'hF);
        for (int i = 0; i < 3; i++) begin
            src[i] <= 1'b1;
            repeat (4) @(posedge core_clk);
            rd(`WDRS_OFS_CAUSE, 32'h1 << cbit[i]);
            src[i] <= 1'b0;
            rd(`WDRS_OFS_EVT, 32'h1 << ebit[i]);
            irq_is(1'b1);
            wr(`WDRS_OFS_MASK, 32'h0);
            irq_is(1'b0);
            wr(`WDRS_OFS_MASK, 32'hF);
            wr(`WDRS_OFS_EVT, 32'h1 << ebit[i]);
            irq_is(1'b0);
            wr(`WDRS_OFS_CAUSE, 32'h0);
            rd(`WDRS_OFS_CAUSE, 32'h0);
        end
        always_on_fuse <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(`WDRS_OFS_CTRL, 32'h08);
        wr(`WDRS_OFS_CTRL, 32'h18);
        wr(`WDRS_OFS_CTRL, 32'h00);
        rd(`WDRS_OFS_CTRL, 32'h08);
        always_on_fuse <= 1'b0;
        src[0] <= 1'b1;
        repeat (4) @(posedge core_clk);
        src[0] <= 1'b0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        rd(`WDRS_OFS_CAUSE, 32'h01);
        rd(`WDRS_OFS_CTRL, 32'h00);
        @(posedge core_clk);
        `CHK(pq.size(), 0)
        report_and_stop();
    end
endmodule
